// *** hw/lcp_pkg.sv ***
// constants, field positions and timing for the protected LED driver config bank
// assumes one 100 MHz system clock and byte-wide registers at their own addresses
//
// Operation
// [RQ1] protected registers are writable only while the unlock key register holds c5.
// [RQ2] test, trim, headroom, switch-test and LED-test registers are protected; the oscillator fine and coarse trims are not.
// [RQ3] the unlock key clears to zero after 10, 20, 50 or 100 ms picked by a two-bit window.
// [RQ4] test mode is entered only when the test entry code is 1001; test select picks the mode.
// [RQ5] each mask packs 12 pixels per row lsb first, rows running on across byte edges.
// [RQ6] a set mask bit turns its pixel off, and mask changes apply only at a frame boundary.
// [RQ7] a 24-bit sink offset trim over three bytes gives each of 12 sinks a 2-bit code.
// [RQ8] an overtemp disable bit turns protection off and a 2-bit range trim defaults to 00.
// [RQ9] pull test byte: bit 7 sink pull-up, bit 6 switch pull-down, bits 5-4 oc trim.
// [RQ10] separate sink and switch headroom enables plus one test enable per switch row.
// [RQ11] a sweep rate of 0000 turns spread spectrum off; other values set the sweep rate.
// [RQ12] spread amplitude 00/01/10/11 swings the fine trim by 16/32/64/125.
// [RQ13] the fine trim resets to 80, a larger value meaning a lower frequency.
// [RQ14] a three-bit coarse trim picks one of eight oscillator ranges.
// [RQ15] every unlock key write restarts the relock timer; expiry clears the key.
// [RQ16] locked writes to protected registers are dropped silently.

package lcp_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_MASK_D = 32'h4001_00e7;
  localparam logic [31:0] ADDR_MASK_E = 32'h4001_00e8;
  localparam logic [31:0] ADDR_MASK_F = 32'h4001_00e9;
  localparam logic [31:0] ADDR_MASK_G = 32'h4001_00ea;
  localparam logic [31:0] ADDR_MASK_H = 32'h4001_00eb;
  localparam logic [31:0] ADDR_MASK_I = 32'h4001_00ec;
  localparam logic [31:0] ADDR_MASK_J = 32'h4001_00ed;
  localparam logic [31:0] ADDR_MASK_K = 32'h4001_00ee;
  localparam logic [31:0] ADDR_MASK_L = 32'h4001_00ef;
  localparam logic [31:0] ADDR_UNLOCK_KEY = 32'h4001_00f0;
  localparam logic [31:0] ADDR_TEST_MODE = 32'h4001_00f1;
  localparam logic [31:0] ADDR_BANDGAP_TRIM = 32'h4001_00f2;
  localparam logic [31:0] ADDR_REF_TRIM = 32'h4001_00f3;
  localparam logic [31:0] ADDR_OFS_GLOBAL = 32'h4001_00f4;
  localparam logic [31:0] ADDR_OFS_LOW = 32'h4001_00f5;
  localparam logic [31:0] ADDR_OFS_MID = 32'h4001_00f6;
  localparam logic [31:0] ADDR_OFS_HIGH = 32'h4001_00f7;
  localparam logic [31:0] ADDR_HEADROOM = 32'h4001_00f8;
  localparam logic [31:0] ADDR_ROW_TEST = 32'h4001_00f9;
  localparam logic [31:0] ADDR_OVERTEMP = 32'h4001_00fa;
  localparam logic [31:0] ADDR_PULL_TEST = 32'h4001_00fb;
  localparam logic [31:0] ADDR_WINDOW = 32'h4001_00fc;
  localparam logic [31:0] ADDR_SPREAD = 32'h4001_00fd;
  localparam logic [31:0] ADDR_FINE = 32'h4001_00fe;
  localparam logic [31:0] ADDR_COARSE = 32'h4001_00ff;

  localparam int NREG = 25;
  localparam int NMASK = 9;
  localparam int NROW = 6;
  localparam int NSINK = 12;
  typedef logic [4:0] lcp_idx_t;

  // register index = address minus first address
  localparam lcp_idx_t I_KEY = lcp_idx_t'(ADDR_UNLOCK_KEY - ADDR_MASK_D);
  localparam lcp_idx_t I_TEST = lcp_idx_t'(ADDR_TEST_MODE - ADDR_MASK_D);
  localparam lcp_idx_t I_BG = lcp_idx_t'(ADDR_BANDGAP_TRIM - ADDR_MASK_D);
  localparam lcp_idx_t I_REF = lcp_idx_t'(ADDR_REF_TRIM - ADDR_MASK_D);
  localparam lcp_idx_t I_OFSG = lcp_idx_t'(ADDR_OFS_GLOBAL - ADDR_MASK_D);
  localparam lcp_idx_t I_OFS0 = lcp_idx_t'(ADDR_OFS_LOW - ADDR_MASK_D);
  localparam lcp_idx_t I_OFS1 = lcp_idx_t'(ADDR_OFS_MID - ADDR_MASK_D);
  localparam lcp_idx_t I_OFS2 = lcp_idx_t'(ADDR_OFS_HIGH - ADDR_MASK_D);
  localparam lcp_idx_t I_HEAD = lcp_idx_t'(ADDR_HEADROOM - ADDR_MASK_D);
  localparam lcp_idx_t I_ROWT = lcp_idx_t'(ADDR_ROW_TEST - ADDR_MASK_D);
  localparam lcp_idx_t I_OTEMP = lcp_idx_t'(ADDR_OVERTEMP - ADDR_MASK_D);
  localparam lcp_idx_t I_PULL = lcp_idx_t'(ADDR_PULL_TEST - ADDR_MASK_D);
  localparam lcp_idx_t I_WIN = lcp_idx_t'(ADDR_WINDOW - ADDR_MASK_D);
  localparam lcp_idx_t I_SPRD = lcp_idx_t'(ADDR_SPREAD - ADDR_MASK_D);
  localparam lcp_idx_t I_FINE = lcp_idx_t'(ADDR_FINE - ADDR_MASK_D);
  localparam lcp_idx_t I_COARSE = lcp_idx_t'(ADDR_COARSE - ADDR_MASK_D);

  // protected set: test mode through pull test byte
  localparam logic [NREG-1:0] PROT_MAP = 25'h01ffc00;
  // writable bits per register, index 0 rightmost; reserved bits read zero
  localparam logic [NREG-1:0][7:0] WMASK = {
    8'h07, 8'hff, 8'hfc, 8'h30, 8'hf0, 8'h0b, 8'hff, 8'hc0,
    8'hff, 8'hff, 8'hff, 8'hc0, 8'h3f, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] FINE_RST = 8'h80;

  // codes
  localparam logic [7:0] KEY_OPEN = 8'hc5;
  localparam logic [3:0] TEST_ENTRY = 4'h9;
  localparam logic [3:0] SWEEP_OFF = 4'h0;
  localparam logic [3:0][6:0] SWING = {7'h7d, 7'h40, 7'h20, 7'h10};

  // field positions
  localparam int WIN_LSB = 4;
  localparam int TEN_LSB = 4;
  localparam int TSEL_LSB = 0;
  localparam int BGEN_BIT = 7;
  localparam int ISM_LSB = 4;
  localparam int TBG_LSB = 0;
  localparam int ISET_LSB = 0;
  localparam int OSG_LSB = 6;
  localparam int SINK_HR_BIT = 7;
  localparam int SW_HR_BIT = 6;
  localparam int OTDIS_BIT = 3;
  localparam int OTR_LSB = 0;
  localparam int PU_BIT = 7;
  localparam int PD_BIT = 6;
  localparam int OC_LSB = 4;
  localparam int SWEEP_LSB = 4;
  localparam int AMP_LSB = 2;
  localparam int COARSE_LSB = 0;

  // relock windows
  localparam int CLK_KHZ = 100000;
  localparam int WIN0_MS = 10;
  localparam int WIN1_MS = 20;
  localparam int WIN2_MS = 50;
  localparam int WIN3_MS = 100;

endpackage

// *** hw/lcp_config_bank.sv ***
// protected configuration bank of the LED matrix driver: pixel masks for
// rows 3 to 8, unlock key with timed relock, protected test and trim bytes,
// and oscillator spread and trim controls
// assumes a byte register port on sys_clk and a frame start pulse from the
// scan logic on the same clock

`timescale 1ns/100ps
`default_nettype none

module lcp_config_bank #(
  parameter int unsigned RELOCK_CYC_0 = lcp_pkg::WIN0_MS * lcp_pkg::CLK_KHZ,
  parameter int unsigned RELOCK_CYC_1 = lcp_pkg::WIN1_MS * lcp_pkg::CLK_KHZ,
  parameter int unsigned RELOCK_CYC_2 = lcp_pkg::WIN2_MS * lcp_pkg::CLK_KHZ,
  parameter int unsigned RELOCK_CYC_3 = lcp_pkg::WIN3_MS * lcp_pkg::CLK_KHZ,
  parameter int TMR_W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [31:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic frame_start,
  output logic [lcp_pkg::NROW-1:0][lcp_pkg::NSINK-1:0] pixel_off,
  output logic unlocked,
  output logic test_mode_on,
  output logic [3:0] test_select,
  output logic bg_test_en,
  output logic [2:0] iset_small_trim,
  output logic [3:0] bandgap_trim,
  output logic [5:0] iset_trim,
  output logic [1:0] sink_offset_global,
  output logic [23:0] sink_offset_code,
  output logic sink_headroom_test,
  output logic switch_headroom_test,
  output logic [7:0] row_switch_test,
  output logic overtemp_disable,
  output logic [1:0] overtemp_range_trim,
  output logic sink_pullup_test,
  output logic switch_pulldown_test,
  output logic [1:0] switch_oc_trim,
  output logic spread_on,
  output logic [3:0] spread_sweep_rate,
  output logic [6:0] spread_swing,
  output logic [7:0] osc_fine_code,
  output logic [2:0] osc_coarse_code
);

  typedef struct packed {
    logic [lcp_pkg::NREG-1:0][7:0] regs;
    logic [TMR_W-1:0] relock_cnt;
    logic [7:0] rdata;
    logic [lcp_pkg::NROW-1:0][lcp_pkg::NSINK-1:0] pix;
    logic unlocked;
    logic test_on;
    logic spread_on;
    logic [6:0] swing;
  } lcp_state_t;

  lcp_state_t s_r;
  lcp_state_t s_nxt;

  logic hit;
  lcp_pkg::lcp_idx_t idx;
  logic [31:0] rel_addr;
  logic [TMR_W-1:0] win_load;
  logic [lcp_pkg::NMASK*8-1:0] mask_flat;
  logic [1:0] win_sel;
  logic [1:0] amp_sel;

  // address decode: one contiguous byte range
  assign rel_addr = reg_addr - lcp_pkg::ADDR_MASK_D;
  assign hit = (reg_addr >= lcp_pkg::ADDR_MASK_D) && (reg_addr <= lcp_pkg::ADDR_COARSE);
  assign idx = lcp_pkg::lcp_idx_t'(rel_addr);

  // window picked at the moment the key is written, not while counting
  assign win_sel = s_r.regs[lcp_pkg::I_WIN][lcp_pkg::WIN_LSB +: 2];
  assign amp_sel = s_nxt.regs[lcp_pkg::I_SPRD][lcp_pkg::AMP_LSB +: 2];

  // relock interval in cycles for the selected window
  always_comb begin
    unique case (win_sel)
      2'h0: win_load = TMR_W'(RELOCK_CYC_0); // RQ3
      2'h1: win_load = TMR_W'(RELOCK_CYC_1); // RQ3
      2'h2: win_load = TMR_W'(RELOCK_CYC_2); // RQ3
      2'h3: win_load = TMR_W'(RELOCK_CYC_3); // RQ3
    endcase
  end

  // mask bytes joined lsb first so that rows run on across byte edges
  always_comb begin
    mask_flat = '0;
    for (int b = 0; b < lcp_pkg::NMASK; b++) begin
      mask_flat[b*8 +: 8] = s_r.regs[b]; // RQ5
    end
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;

    // read answers in the next cycle only; unmapped reads give zero
    if (reg_rd && hit) begin
      s_nxt.rdata = s_r.regs[idx];
    end

    // relock countdown; expiry clears the key and so relocks
    if (s_r.relock_cnt != '0) begin
      s_nxt.relock_cnt = s_r.relock_cnt - 1'b1;
      if (s_r.relock_cnt == TMR_W'(1)) begin
        s_nxt.regs[lcp_pkg::I_KEY] = '0; // RQ3 RQ15
      end
    end

    // writes; locked writes to the protected set fall away silently
    if (reg_wr && hit) begin
      if (!lcp_pkg::PROT_MAP[idx] || s_r.unlocked) begin // RQ1 RQ2 RQ16
        s_nxt.regs[idx] = reg_wdata & lcp_pkg::WMASK[idx];
      end
      // any key write restarts the window, also one landing on expiry
      if (idx == lcp_pkg::I_KEY) begin
        s_nxt.relock_cnt = win_load; // RQ15
      end
    end

    // masks reach the switches only at a frame start so no frame tears
    if (frame_start) begin
      for (int r = 0; r < lcp_pkg::NROW; r++) begin
        s_nxt.pix[r] = mask_flat[r*lcp_pkg::NSINK +: lcp_pkg::NSINK]; // RQ5 RQ6
      end
    end

    // decoded states, kept as flops so the outputs are registered
    s_nxt.unlocked = s_nxt.regs[lcp_pkg::I_KEY] == lcp_pkg::KEY_OPEN; // RQ1
    s_nxt.test_on = s_nxt.regs[lcp_pkg::I_TEST][lcp_pkg::TEN_LSB +: 4]
                    == lcp_pkg::TEST_ENTRY; // RQ4
    s_nxt.spread_on = s_nxt.regs[lcp_pkg::I_SPRD][lcp_pkg::SWEEP_LSB +: 4]
                      != lcp_pkg::SWEEP_OFF; // RQ11
    s_nxt.swing = lcp_pkg::SWING[amp_sel]; // RQ12
  end

  // state register; reset wins over the clock enable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.regs[lcp_pkg::I_FINE] <= lcp_pkg::FINE_RST; // RQ13
      s_r.swing <= lcp_pkg::SWING[0];
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // register port and lock status
  assign reg_rdata = s_r.rdata;
  assign unlocked = s_r.unlocked;

  // a set bit opens the sink switch of that pixel
  assign pixel_off = s_r.pix; // RQ6

  // test mode
  assign test_mode_on = s_r.test_on; // RQ4
  assign test_select = s_r.regs[lcp_pkg::I_TEST][lcp_pkg::TSEL_LSB +: 4]; // RQ4

  // reference trims
  assign bg_test_en = s_r.regs[lcp_pkg::I_BG][lcp_pkg::BGEN_BIT];
  assign iset_small_trim = s_r.regs[lcp_pkg::I_BG][lcp_pkg::ISM_LSB +: 3];
  assign bandgap_trim = s_r.regs[lcp_pkg::I_BG][lcp_pkg::TBG_LSB +: 4];
  assign iset_trim = s_r.regs[lcp_pkg::I_REF][lcp_pkg::ISET_LSB +: 6];

  // sink n owns bits 2n+1:2n of the offset code
  assign sink_offset_global = s_r.regs[lcp_pkg::I_OFSG][lcp_pkg::OSG_LSB +: 2];
  assign sink_offset_code = {s_r.regs[lcp_pkg::I_OFS2],
                             s_r.regs[lcp_pkg::I_OFS1],
                             s_r.regs[lcp_pkg::I_OFS0]}; // RQ7

  // headroom and row switch tests
  assign sink_headroom_test = s_r.regs[lcp_pkg::I_HEAD][lcp_pkg::SINK_HR_BIT]; // RQ10
  assign switch_headroom_test = s_r.regs[lcp_pkg::I_HEAD][lcp_pkg::SW_HR_BIT]; // RQ10
  assign row_switch_test = s_r.regs[lcp_pkg::I_ROWT]; // RQ10

  // overtemperature
  assign overtemp_disable = s_r.regs[lcp_pkg::I_OTEMP][lcp_pkg::OTDIS_BIT]; // RQ8
  assign overtemp_range_trim = s_r.regs[lcp_pkg::I_OTEMP][lcp_pkg::OTR_LSB +: 2]; // RQ8

  // pull tests; low nibble is reserved and always zero
  assign sink_pullup_test = s_r.regs[lcp_pkg::I_PULL][lcp_pkg::PU_BIT]; // RQ9
  assign switch_pulldown_test = s_r.regs[lcp_pkg::I_PULL][lcp_pkg::PD_BIT]; // RQ9
  assign switch_oc_trim = s_r.regs[lcp_pkg::I_PULL][lcp_pkg::OC_LSB +: 2]; // RQ9

  // oscillator; the analog core adds the swing around the fine code
  assign spread_on = s_r.spread_on; // RQ11
  assign spread_sweep_rate = s_r.regs[lcp_pkg::I_SPRD][lcp_pkg::SWEEP_LSB +: 4]; // RQ11
  assign spread_swing = s_r.swing; // RQ12
  assign osc_fine_code = s_r.regs[lcp_pkg::I_FINE]; // RQ13
  assign osc_coarse_code = s_r.regs[lcp_pkg::I_COARSE][lcp_pkg::COARSE_LSB +: 3]; // RQ14

endmodule // lcp_config_bank

`default_nettype wire

// *** test/lcp_config_bank_assertions.sv ***
// concurrent checks on the protected config bank, bound to the design
// assumes only the design's ports and the package constants
`timescale 1ns/100ps
`default_nettype none
module lcp_config_bank_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [31:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic frame_start,
  input wire logic [lcp_pkg::NROW-1:0][lcp_pkg::NSINK-1:0] pixel_off,
  input wire logic unlocked,
  input wire logic test_mode_on,
  input wire logic [3:0] test_select,
  input wire logic spread_on,
  input wire logic [3:0] spread_sweep_rate,
  input wire logic [6:0] spread_swing,
  input wire logic [7:0] osc_fine_code,
  input wire logic [2:0] osc_coarse_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // decoded accepted strobes, so each property stays short
  logic wk, wt, ws;
  logic [1:0] sa;
  assign wk = clk_en && reg_wr && reg_addr == lcp_pkg::ADDR_UNLOCK_KEY;
  assign wt = clk_en && reg_wr && reg_addr == lcp_pkg::ADDR_TEST_MODE;
  assign ws = clk_en && reg_wr && reg_addr == lcp_pkg::ADDR_SPREAD;
  assign sa = reg_wdata[3:2];
  a_key_opens: assert property (wk && reg_wdata == 8'hc5 |=> unlocked)
    else $error("unlock key did not open the bank");
  a_key_closes: assert property (wk && reg_wdata != 8'hc5 |=> !unlocked)
    else $error("wrong key left the bank open");
  a_test_entry: assert property (wt && unlocked |=>
    test_mode_on == ($past(reg_wdata) >> 4 == 8'h09) && test_select == $past(reg_wdata[3:0]))
    else $error("test entry decode wrong");
  a_locked_drop: assert property (wt && !unlocked |=> $stable(test_select))
    else $error("locked write changed test select");
  a_sweep_off: assert property (spread_on == (spread_sweep_rate != 4'h0))
    else $error("spread enable disagrees with sweep rate");
  a_swing_map: assert property (ws |=> spread_swing == lcp_pkg::SWING[$past(sa)])
    else $error("spread swing wrong");
  a_mask_hold: assert property (!(clk_en && frame_start) |=> $stable(pixel_off))
    else $error("pixel mask changed mid frame");
  a_fine_read: assert property (clk_en && reg_rd && reg_addr == lcp_pkg::ADDR_FINE |=>
    reg_rdata == osc_fine_code) else $error("fine trim read wrong");
  a_coarse_read: assert property (clk_en && reg_rd && reg_addr == lcp_pkg::ADDR_COARSE |=>
    reg_rdata == {5'h00, osc_coarse_code}) else $error("coarse trim read wrong");
  c_unlock: cover property (wk ##1 unlocked);
  c_frame: cover property (clk_en && frame_start);
  c_locked: cover property (wt && !unlocked);
endmodule // lcp_config_bank_assertions
bind lcp_config_bank lcp_config_bank_assertions lcp_config_bank_assertions_inst (
  .sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .frame_start, .pixel_off, .unlocked, .test_mode_on, .test_select, .spread_on,
  .spread_sweep_rate, .spread_swing, .osc_fine_code, .osc_coarse_code);
`default_nettype wire

// *** test/tb_lcp_config_bank.sv ***
// self-checking bench for the protected config bank
// assumes short relock counts so every window fits in a short run
`timescale 1ns/100ps
`default_nettype none
module tb_lcp_config_bank;
  localparam int RC [4] = '{20, 40, 100, 200};
  localparam logic [6:0] SW [4] = '{7'h10, 7'h20, 7'h40, 7'h7d};
  logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, frame_start = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, osc_fine_code;
  logic [5:0][11:0] pixel_off;
  logic unlocked, test_mode_on, sink_pullup_test, switch_pulldown_test, overtemp_disable;
  logic spread_on, sink_headroom_test, switch_headroom_test;
  logic [3:0] test_select, spread_sweep_rate;
  logic [1:0] switch_oc_trim, overtemp_range_trim;
  logic [23:0] sink_offset_code;
  logic [6:0] spread_swing;
  logic [2:0] osc_coarse_code, iset_small_trim;
  logic bg_test_en;
  logic [3:0] bandgap_trim;
  logic [5:0] iset_trim;
  logic [1:0] sink_offset_global;
  logic [7:0] row_switch_test;
  logic [71:0] exp_mask;
  int mismatches = 0, checks = 0, cyc = 0, n;
  lcp_config_bank #(.RELOCK_CYC_0(20), .RELOCK_CYC_1(40), .RELOCK_CYC_2(100),
    .RELOCK_CYC_3(200)) lcp_config_bank_inst (.sys_clk, .rst_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_start, .pixel_off, .unlocked,
    .test_mode_on, .test_select, .bg_test_en, .iset_small_trim, .bandgap_trim,
    .iset_trim, .sink_offset_global, .sink_offset_code, .sink_headroom_test,
    .switch_headroom_test, .row_switch_test, .overtemp_disable, .overtemp_range_trim,
    .sink_pullup_test, .switch_pulldown_test, .switch_oc_trim, .spread_on,
    .spread_sweep_rate, .spread_swing, .osc_fine_code, .osc_coarse_code);
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle strobes; a spare edge between calls keeps back-to-back strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= {24'h400100, a};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= {24'h400100, a};
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, "rdata");
  endtask
  // counts edges from the key write until the bank locks again
  task automatic wait_lock;
    n = 0;
    while (unlocked === 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard, far above the whole sequence
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 25; i++) rd(8'he7 + 8'(i), (i == 23) ? 8'h80 : 8'h00);
    rd(8'he6, 8'h00);
    wr(8'hf1, 8'h9a);
    rd(8'hf1, 8'h00);
    chk(test_mode_on, 1'b0, "test_mode_on");
    // longest window so the whole protected sweep fits before relock
    wr(8'hfc, 8'h30);
    wr(8'hf0, 8'hc5);
    chk(unlocked, 1'b1, "unlocked");
    for (int i = 10; i < 21; i++) begin
      wr(8'he7 + 8'(i), 8'hff);
      rd(8'he7 + 8'(i), lcp_pkg::WMASK[i]);
    end
    wr(8'hf1, 8'h9a);
    chk({test_mode_on, test_select}, 5'h1a, "test entry");
    wr(8'hf1, 8'h8a);
    chk(test_mode_on, 1'b0, "test_mode_on");
    wr(8'hfb, 8'ha5);
    chk({sink_pullup_test, switch_pulldown_test, switch_oc_trim}, 4'ha, "pull");
    wr(8'hf5, 8'h1b);
    wr(8'hf6, 8'he4);
    wr(8'hf7, 8'hc6);
    chk(sink_offset_code, 24'hc6e41b, "offset");
    wr(8'hfa, 8'h0a);
    chk({overtemp_disable, overtemp_range_trim}, 3'h6, "overtemp");
    wr(8'hf8, 8'h40);
    chk({sink_headroom_test, switch_headroom_test}, 2'h1, "headroom");
    // distinct patterns so a swapped field shows up
    wr(8'hf2, 8'ha5);
    wr(8'hf3, 8'h2a);
    wr(8'hf4, 8'h80);
    wr(8'hf9, 8'h3c);
    chk({bg_test_en, iset_small_trim, bandgap_trim}, 8'ha5, "bandgap");
    chk({iset_trim, sink_offset_global}, 8'haa, "ref trim");
    chk(row_switch_test, 8'h3c, "row test");
    wr(8'hf0, 8'h5c);
    chk(unlocked, 1'b0, "unlocked");
    wr(8'hf8, 8'h80);
    rd(8'hf8, 8'h40);
    for (int w = 0; w < 4; w++) begin
      wr(8'hfc, 8'(w << 4));
      wr(8'hf0, 8'hc5);
      wait_lock;
      chk(n, RC[w], "relock");
    end
    rd(8'hf0, 8'h00);
    wr(8'hf0, 8'hc5);
    repeat (10) @(posedge sys_clk);
    wr(8'hf0, 8'hc5);
    wait_lock;
    chk(n, RC[3], "restart");
    for (int i = 0; i < 9; i++) begin
      exp_mask[i*8 +: 8] = 8'(i * 37 + 1);
      wr(8'he7 + 8'(i), 8'(i * 37 + 1));
    end
    chk(pixel_off, 72'h0, "pixel_off");
    @(posedge sys_clk);
    frame_start <= 1'b1;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    #1;
    chk(pixel_off, exp_mask, "pixel_off");
    for (int i = 0; i < 4; i++) begin
      wr(8'hfd, 8'((i * 5) << 4 | i << 2));
      chk({spread_on, spread_swing}, {i != 0, SW[i]}, "spread");
    end
    wr(8'hfe, 8'h33);
    chk(osc_fine_code, 8'h33, "fine");
    // with the enable low a write must not land
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'hfe, 8'h55);
    chk(osc_fine_code, 8'h33, "frozen fine");
    @(posedge sys_clk);
    clk_en <= 1'b1;
    wr(8'hff, 8'hff);
    rd(8'hff, 8'h07);
    chk(osc_coarse_code, 3'h7, "coarse");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'hfe, 8'h80);
    final_report;
  end
endmodule // tb_lcp_config_bank
`default_nettype wire
